// ===== rtl/sdrb_pkg.sv
// constants and carriers for the read burst block
// assumes one link clock domain facing the command pins and one register clock domain
package sdrb_pkg;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] TIMING_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	localparam logic [3:0] SYNC_OFS = 4'hC;
	localparam int BMODE_LSB = 0;
	localparam int PRE2_BIT = 2;
	localparam int CL_LSB = 4;
	localparam int ALSEL_LSB = 12;
	localparam int TRAS_LSB = 0;
	localparam int TRP_LSB = 8;
	localparam logic [1:0] BM_BL8 = 2'h0;
	localparam logic [1:0] BM_OTF = 2'h1;
	localparam logic [1:0] BM_BC4 = 2'h2;
	localparam logic [1:0] AL_CLM1 = 2'h1;
	localparam logic [1:0] AL_CLM2 = 2'h2;
	localparam int PIPE_N = 64;
	localparam int NBANK = 16;
	localparam logic [2:0] BL8_LEFT = 3'h3;
	localparam logic [2:0] BC4_LEFT = 3'h1;
	localparam logic [2:0] BL8_CLK = 3'h4;
	localparam logic [2:0] BC4_CLK = 3'h2;
	localparam logic [1:0] DQS_TOGGLE = 2'h1;
	localparam logic [1:0] DQS_PRE = 2'h0;
	localparam logic [4:0] CL_RST = 5'h0B;
	localparam logic [5:0] TRAS_RST = 6'h20;
	localparam logic [5:0] TRP_RST = 6'h10;
	typedef enum logic [1:0] {OS_IDLE = 2'b00, OS_PRE = 2'b01, OS_DATA = 2'b11} sdrb_ost_t;
	typedef struct packed {
		logic cs_n;
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] bg;
		logic [1:0] ba;
		logic [13:0] a;
	} sdrb_cmd_t;
	typedef struct packed {
		logic v;
		logic bc4;
		logic ap;
		logic [3:0] bank;
		logic [7:0] col;
	} sdrb_ent_t;
	typedef struct packed {
		logic [5:0] trp;
		logic [5:0] tras;
		logic [1:0] alsel;
		logic [4:0] cl;
		logic pre2;
		logic [1:0] bmode;
	} sdrb_cfg_t;
	localparam sdrb_cfg_t CFG_RST = '{TRP_RST, TRAS_RST, 2'h0, CL_RST, 1'b0, BM_BL8};
endpackage : sdrb_pkg

// ===== rtl/sdrb_read_burst.sv
// read burst engine: command decode, read latency, strobe and data sequencing, bank auto-precharge
// assumes command pins are launched on the link clock ck and the register port on mclk
// Function
// R1: on-the-fly mode: A12 low chops, high full
// R2: fixed eight, fixed chop, or per-command choice
// R3: read without A10 leaves bank open
// R4: read with A10 precharges bank itself
// R5: read latency equals additive plus CAS latency
// R6: eight beats for mode 00 or 01+A12
// R7: four beats for mode 10 or 01+!A12
// R8: controller avoids five-clock gap with long preamble
// R9: reads four clocks apart stream gaplessly
// R10: short preamble, five apart: fresh preamble
// R11: long preamble, six apart: full preamble
// R12: chopped reads four apart give four beats
// R13: controller spaces write eight after read
// R14: drive ends RL+4 or RL+2 clocks
// R15: auto-precharge waits row time, then precharge time
// R16: data on both strobe edges, toggling
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module sdrb_read_burst
	import sdrb_pkg::*;
(
	input wire logic mclk, // register clock
	input wire logic rst_n, // async reset, active low
	input wire logic [3:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic ck, // link clock
	input wire sdrb_cmd_t ck_cmd, // command pins on ck
	output logic [15:0] dq_o, // beat pair, low byte first half
	output logic dq_oe, // data drive enable
	output logic [1:0] dqs_o, // strobe level per half clock
	output logic dqs_oe // strobe drive enable
);
	typedef struct packed {
		sdrb_cfg_t cfg;
		sdrb_cfg_t tx;
		logic req;
		logic ack_s1;
		logic ack_s2;
		logic [31:0] stat;
		logic [31:0] rdata;
	} sdrb_mst_t;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic ack;
		sdrb_cfg_t cfg;
		logic [31:0] stat;
		logic [PIPE_N-1:0][14:0] pipe;
		sdrb_ost_t ost;
		logic [2:0] left;
		logic [7:0] col;
		logic [15:0] dq;
		logic dq_oe;
		logic [1:0] dqs;
		logic dqs_oe;
		logic [NBANK-1:0] open;
		logic [NBANK-1:0] ap;
		logic [NBANK-1:0][2:0] apw;
		logic [NBANK-1:0][5:0] ras;
		logic [NBANK-1:0][5:0] rp;
	} sdrb_lnk_t;

	localparam sdrb_mst_t MST_RST = '{CFG_RST, CFG_RST, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0};

	sdrb_mst_t m_q;
	sdrb_mst_t m_d;
	sdrb_lnk_t l_q;
	sdrb_lnk_t l_d;
	logic [1:0] lrst_q;

	// register side
	always_comb begin
		m_d = m_q;
		m_d.ack_s1 = l_q.ack;
		m_d.ack_s2 = m_q.ack_s1;
		// handshake done: snapshot is stable, launch the next config word
		if (m_q.ack_s2 == m_q.req) begin
			m_d.stat = l_q.stat;
			m_d.tx = m_q.cfg;
			m_d.req = ~m_q.req;
		end

		// a write in a handshake cycle waits for the next round
		if (reg_wr) begin
			unique case (reg_addr)
				CTRL_OFS: begin
					m_d.cfg.bmode = reg_wdata[BMODE_LSB +: 2];
					m_d.cfg.pre2 = reg_wdata[PRE2_BIT];
					m_d.cfg.cl = reg_wdata[CL_LSB +: 5];
					m_d.cfg.alsel = reg_wdata[ALSEL_LSB +: 2];
				end
				TIMING_OFS: begin
					m_d.cfg.tras = reg_wdata[TRAS_LSB +: 6];
					m_d.cfg.trp = reg_wdata[TRP_LSB +: 6];
				end
				default: begin
				end
			endcase
		end

		// read data stands one cycle only, zero otherwise
		m_d.rdata = 32'h0;
		if (reg_rd) begin
			unique case (reg_addr)
				CTRL_OFS: begin
					m_d.rdata[BMODE_LSB +: 2] = m_q.cfg.bmode;
					m_d.rdata[PRE2_BIT] = m_q.cfg.pre2;
					m_d.rdata[CL_LSB +: 5] = m_q.cfg.cl;
					m_d.rdata[ALSEL_LSB +: 2] = m_q.cfg.alsel;
				end
				TIMING_OFS: begin
					m_d.rdata[TRAS_LSB +: 6] = m_q.cfg.tras;
					m_d.rdata[TRP_LSB +: 6] = m_q.cfg.trp;
				end
				STATUS_OFS: begin
					m_d.rdata = m_q.stat;
				end
				SYNC_OFS: begin
					m_d.rdata[0] = (m_q.tx == m_q.cfg);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			m_q <= MST_RST;
		end else begin
			m_q <= m_d;
		end
	end

	// reset release retimed into ck; assertion stays asynchronous
	// the ck side leaves reset two edges later, so no command is taken half reset
	always_ff @(posedge ck or negedge rst_n) begin
		if (!rst_n) begin
			lrst_q <= 2'h0;
		end else begin
			lrst_q <= {lrst_q[0], 1'b1};
		end
	end

	// link side
	always_comb begin
		logic rd_cmd;
		logic act_cmd;
		logic pre_cmd;
		logic [3:0] bank;
		logic [5:0] al;
		logic [5:0] rl;
		logic [NBANK-1:0] busy_rp;
		sdrb_ent_t nw;
		sdrb_ent_t lch;
		sdrb_ent_t pr1;
		sdrb_ent_t pr2;
		rd_cmd = 1'b0;
		act_cmd = 1'b0;
		pre_cmd = 1'b0;
		bank = 4'h0;
		al = 6'h0;
		rl = 6'h0;
		busy_rp = '0;
		nw = '0;
		lch = '0;
		pr1 = '0;
		pr2 = '0;
		l_d = l_q;
		l_d.req_s1 = m_q.req;
		l_d.req_s2 = l_q.req_s1;
		// a bank stays busy from auto-precharge request until its precharge time has run out
		for (int b = 0; b < NBANK; b++) begin
			busy_rp[b] = (l_q.rp[b] != 6'h0);
		end
		// tx is only taken once req has crossed, so the config word is already stable here
		if (l_q.req_s2 != l_q.ack) begin
			l_d.cfg = m_q.tx;
			l_d.stat = {l_q.ap | busy_rp, l_q.open};
			l_d.ack = l_q.req_s2;
		end

		// command decode; act_n low means activate whatever the other strobes show
		rd_cmd = !ck_cmd.cs_n && ck_cmd.act_n && ck_cmd.ras_n && !ck_cmd.cas_n && ck_cmd.we_n;
		act_cmd = !ck_cmd.cs_n && !ck_cmd.act_n;
		pre_cmd = !ck_cmd.cs_n && ck_cmd.act_n && !ck_cmd.ras_n && ck_cmd.cas_n && !ck_cmd.we_n;
		bank = {ck_cmd.bg, ck_cmd.ba};

		// R5: latency sum
		unique case (l_q.cfg.alsel)
			AL_CLM1: al = {1'b0, l_q.cfg.cl} - 6'h1;
			AL_CLM2: al = {1'b0, l_q.cfg.cl} - 6'h2;
			default: al = 6'h0;
		endcase
		rl = {1'b0, l_q.cfg.cl} + al;

		// R2 R6: choose length
		nw.v = rd_cmd;
		nw.bc4 = (l_q.cfg.bmode == BM_BC4);
		// R1 R7: A12 low chops
		if (l_q.cfg.bmode == BM_OTF) begin
			nw.bc4 = !ck_cmd.a[12];
		end
		// R3 R4: A10 picks auto-precharge
		nw.ap = ck_cmd.a[10];
		nw.bank = bank;
		nw.col = ck_cmd.a[7:0];

		// pipe depth caps read latency at 63 clocks; larger sums wrap the tap index
		l_d.pipe = {l_q.pipe[PIPE_N-2:0], nw};
		lch = l_q.pipe[rl - 6'h2];
		pr1 = l_q.pipe[rl - 6'h3];
		pr2 = l_q.pipe[rl - 6'h4];

		// R9 R12: a launch overrides the preamble window, so eight-beat reads spaced four stream gaplessly
		if (lch.v) begin
			l_d.ost = OS_DATA;
			l_d.left = lch.bc4 ? BC4_LEFT : BL8_LEFT;
			l_d.col = lch.col;
			if (lch.ap) begin
				l_d.ap[lch.bank] = 1'b1;
			end
		end else if (l_q.ost == OS_DATA && l_q.left != 3'h0) begin
			l_d.left = l_q.left - 3'h1;
			l_d.col = l_q.col + 8'h2;
		// R10 R11: fresh preamble after any gap; R8 keeps the long one whole
		end else if (pr1.v || (l_q.cfg.pre2 && pr2.v)) begin
			l_d.ost = OS_PRE;
		end else begin
			// R14: drive ends after last beat pair
			l_d.ost = OS_IDLE;
		end

		// R16: beat per half clock, strobe toggles
		// idle and preamble carry zero data so a stray beat is easy to spot
		l_d.dq = 16'h0;
		l_d.dqs = DQS_PRE;
		l_d.dq_oe = (l_d.ost == OS_DATA);
		l_d.dqs_oe = (l_d.ost != OS_IDLE);
		if (l_d.ost == OS_DATA) begin
			l_d.dq = {l_d.col + 8'h1, l_d.col};
			l_d.dqs = DQS_TOGGLE;
		end

		// R15: row time then precharge time
		// row counters saturate so a long-open row never wraps back under the row time
		for (int b = 0; b < NBANK; b++) begin
			if (l_q.open[b] && l_q.ras[b] != 6'h3F) begin
				l_d.ras[b] = l_q.ras[b] + 6'h1;
			end
			if (l_q.rp[b] != 6'h0) begin
				l_d.rp[b] = l_q.rp[b] - 6'h1;
			end
			if (l_q.apw[b] != 3'h0) begin
				l_d.apw[b] = l_q.apw[b] - 3'h1;
			end
			if (l_q.ap[b] && l_q.apw[b] == 3'h0 && l_q.ras[b] >= l_q.cfg.tras) begin
				l_d.ap[b] = 1'b0;
				l_d.open[b] = 1'b0;
				l_d.rp[b] = l_q.cfg.trp;
			end
		end

		// the hold-off spans the burst itself, so precharge never cuts the data
		if (lch.v && lch.ap) begin
			l_d.apw[lch.bank] = lch.bc4 ? BC4_CLK : BL8_CLK;
		end
		if (act_cmd) begin
			l_d.open[bank] = 1'b1;
			l_d.ras[bank] = 6'h0;
		end
		if (pre_cmd) begin
			for (int b = 0; b < NBANK; b++) begin
				if ((ck_cmd.a[10] || bank == 4'(b)) && l_q.open[b]) begin
					l_d.open[b] = 1'b0;
					l_d.rp[b] = l_q.cfg.trp;
				end
			end
		end
	end

	always_ff @(posedge ck or negedge lrst_q[1]) begin
		if (!lrst_q[1]) begin
			l_q <= '{cfg: CFG_RST, ost: OS_IDLE, default: '0};
		end else begin
			l_q <= l_d;
		end
	end

	// every output is a flop of one of the two state words
	assign reg_rdata = m_q.rdata;
	assign dq_o = l_q.dq;
	assign dq_oe = l_q.dq_oe;
	assign dqs_o = l_q.dqs;
	assign dqs_oe = l_q.dqs_oe;
endmodule : sdrb_read_burst

// ===== verif/sdrb_read_burst_assertions.sv
// checker on the link side outputs of the read burst block
// assumes one bind onto every sdrb_read_burst instance
`timescale 1ns/100ps
module sdrb_read_burst_chk
	import sdrb_pkg::*;
(
	input wire logic rst_n, // reset, active low
	input wire logic ck, // link clock
	input wire logic [15:0] dq_o, // beat pair
	input wire logic dq_oe, // data enable
	input wire logic [1:0] dqs_o, // strobe levels
	input wire logic dqs_oe // strobe enable
);
	default clocking @(posedge ck); endclocking
	default disable iff (!rst_n);
	property p_en; dq_oe |-> dqs_oe; endproperty
	a_en: assert property (p_en) else $error("data without strobe");
	property p_tog; dq_oe |-> dqs_o == DQS_TOGGLE; endproperty
	a_tog: assert property (p_tog) else $error("strobe not toggling");
	property p_pre; dqs_oe && !dq_oe |-> dqs_o == DQS_PRE; endproperty
	a_pre: assert property (p_pre) else $error("bad preamble level");
	property p_lead; $rose(dq_oe) |-> $past(dqs_oe); endproperty
	a_lead: assert property (p_lead) else $error("burst without preamble");
	property p_start; $rose(dqs_oe) |-> !dq_oe; endproperty
	a_start: assert property (p_start) else $error("strobe starts in data");
	property p_end; $fell(dqs_oe) |-> $past(dq_oe); endproperty
	a_end: assert property (p_end) else $error("strobe dropped outside data");
	property p_len; $rose(dq_oe) |-> dq_oe [*2]; endproperty
	a_len: assert property (p_len) else $error("burst under two clocks");
	property p_beat; dq_oe |-> dq_o[15:8] == dq_o[7:0] + 8'h01; endproperty
	a_beat: assert property (p_beat) else $error("beat pair out of order");
	c_burst: cover property ($rose(dq_oe));
	c_pre2: cover property (dqs_oe && !dq_oe ##1 dqs_oe && !dq_oe);
	c_fresh: cover property ($fell(dq_oe) ##1 $rose(dq_oe));
endmodule : sdrb_read_burst_chk
bind sdrb_read_burst sdrb_read_burst_chk sdrb_read_burst_chk_inst (.rst_n(rst_n), .ck(ck), .dq_o(dq_o),
	.dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe));

// ===== verif/sdrb_ctl_model.sv
// controller model driving the command pins on the link clock
// assumes send is called just after a rising edge of ck
`timescale 1ns/100ps
module sdrb_ctl_model
	import sdrb_pkg::*;
(
	input wire logic ck, // link clock
	output sdrb_cmd_t cmd // command pins
);
	initial cmd = '1;
	// caller gives the spacing; deselected address lines flip every clock
	task automatic send(input sdrb_cmd_t c, input int gap);
		cmd <= c;
		for (int k = 1; k < gap; k++) begin
			@(posedge ck);
			cmd <= '{cs_n: 1'b1, a: ~cmd.a, default: '1};
		end
		@(posedge ck);
	endtask : send
endmodule : sdrb_ctl_model

// ===== verif/tb.sv
// self-checking bench for the read burst block
// assumes design, checker bind and controller model are compiled first
`timescale 1ns/100ps
module tb;
	import sdrb_pkg::*;
	logic mclk = 1'b0, ck = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [15:0] dq_o;
	logic [1:0] dqs_o, bm = BM_BL8;
	logic dq_oe, dqs_oe;
	sdrb_cmd_t cmd;
	int bad_count = 0, comparisons = 0, seed = 66, cnt = 0, rl = 11;
	int pre_n = 0;
	logic pre2_b = 1'b0, dq_d = 1'b0;
	logic [47:0] dq_q[$];
	logic [31:0] rg_q[$];
	initial forever #4 mclk = ~mclk;
	initial begin
		#3;
		forever #16 ck = ~ck;
	end
	always @(posedge ck) cnt <= cnt + 1;
	sdrb_read_burst sdrb_read_burst_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ck(ck), .ck_cmd(cmd), .dq_o(dq_o),
		.dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe));
	sdrb_ctl_model sdrb_ctl_model_inst (.ck(ck), .cmd(cmd));
	task automatic cmp_b(input logic [47:0] g, input logic [47:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : cmp_b
	task automatic cmp_r(input logic [31:0] g, input logic [31:0] e);
		cmp_b({16'h0, g}, {16'h0, e});
	endtask : cmp_r
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] ad, input logic [31:0] e);
		rg_q.push_back(e);
		@(posedge mclk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic read(input logic [3:0] b, input logic [7:0] c, input logic a12, input logic a10, input int gap);
		int n;
		n = (bm == BM_BC4 || (bm == BM_OTF && !a12)) ? 2 : 4;
		for (int k = 0; k < n; k++) dq_q.push_back({32'(cnt + 1 + rl + k), c + 8'(2 * k + 1), c + 8'(2 * k)});
		sdrb_ctl_model_inst.send('{cs_n: 1'b0, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b0, we_n: 1'b1, bg: b[3:2],
			ba: b[1:0], a: {1'b0, a12, 1'b0, a10, 2'b00, c}}, gap);
	endtask : read
	task automatic sc(input logic [1:0] m, input logic p2, input logic [1:0] al, input logic a1, input logic a2,
		input int gap);
		logic [3:0] b;
		bm = m;
		pre2_b = p2;
		rl = 11 + (al == AL_CLM1 ? 10 : al == AL_CLM2 ? 9 : 0);
		wr(CTRL_OFS, {18'h0, al, 3'h0, CL_RST, 1'b0, p2, m});
		repeat (60) @(posedge mclk);
		rd(SYNC_OFS, 32'h1);
		b = 4'($random(seed));
		@(posedge ck);
		read(b, 8'($random(seed)), a1, 1'b0, gap);
		read(b ^ 4'h4, 8'($random(seed)), a2, 1'b0, 40);
		$display("test mode %0d pre2 %0d al %0d gap %0d done", m, p2, al, gap);
	endtask : sc
	always @(negedge ck) if (dq_oe === 1'b1) cmp_b({32'(cnt), dq_o}, dq_q.size() ? dq_q.pop_front() : 'x);
	always @(negedge ck) begin
		if (dq_oe === 1'b1 && dq_d !== 1'b1) cmp_r(32'(pre_n), pre2_b ? 32'h2 : 32'h1);
		pre_n = (dqs_oe === 1'b1 && dq_oe !== 1'b1) ? pre_n + 1 : 0;
		dq_d = dq_oe;
	end
	always @(posedge mclk) begin
		if (rd_d) cmp_r(reg_rdata, rg_q.pop_front());
		rd_d <= reg_rd;
	end
	initial begin
		#400000;
		bad_count++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ck);
		rd(CTRL_OFS, 32'h000000B0);
		rd(TIMING_OFS, 32'h00001020);
		rd(4'h2, 32'h0);
		sc(BM_BL8, 1'b0, 2'h0, 1'b1, 1'b1, 4);
		sc(BM_BL8, 1'b1, 2'h0, 1'b1, 1'b1, 4);
		sc(BM_BL8, 1'b0, 2'h0, 1'b1, 1'b1, 5);
		sc(BM_BL8, 1'b1, 2'h0, 1'b1, 1'b1, 6);
		sc(BM_OTF, 1'b0, 2'h0, 1'b0, 1'b1, 4);
		sc(BM_OTF, 1'b1, 2'h0, 1'b1, 1'b0, 4);
		sc(BM_BC4, 1'b0, 2'h0, 1'b1, 1'b0, 4);
		sc(2'h3, 1'b1, 2'h0, 1'b0, 1'b0, 6);
		sc(BM_BL8, 1'b0, AL_CLM1, 1'b1, 1'b1, 4);
		sc(BM_OTF, 1'b1, AL_CLM2, 1'b0, 1'b1, 4);
		@(posedge ck);
		sdrb_ctl_model_inst.send('{cs_n: 1'b0, act_n: 1'b0, ba: 2'h1, default: '0}, 2);
		sdrb_ctl_model_inst.send('{cs_n: 1'b0, act_n: 1'b0, ba: 2'h2, default: '0}, 4);
		read(4'h1, 8'h10, 1'b1, 1'b0, 4);
		read(4'h2, 8'h20, 1'b1, 1'b1, 34);
		rd(STATUS_OFS, 32'h00040002);
		repeat (30) @(posedge ck);
		repeat (60) @(posedge mclk);
		rd(STATUS_OFS, 32'h00000002);
		repeat (4) @(posedge mclk);
		$display("test auto precharge done");
		cmp_b(48'(dq_q.size()), 48'h0);
		test_done();
	end
endmodule : tb
